// ### rtl/sss_top.sv
// switch scan sequencer: steps wetting current and comparator routing
// over 24 switch inputs, keeps reference states, raises switch change.
// assumes a synchronous register port, comparator result and chip
// select all synchronous to clk.
//
// The strobed register port and the address map were chosen for this implementation.
module sss_top #(
  parameter int unsigned POLL_BASE_CYC = sss_pkg::POLL_BASE_CYC,
  parameter int unsigned ACT_BASE_CYC  = sss_pkg::ACT_BASE_CYC,
  parameter int unsigned STARTUP_CYC   = sss_pkg::STARTUP_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic              cs_n,
  input  wire logic              comp_above,
  output logic      [4:0]        comp_sel,
  output logic      [23:0][2:0]  current_sel,
  output logic      [1:0]        threshold_sel,
  output logic                   int_n,
  output logic                   switch_change_flag
);

  // register file
  sss_pkg::sss_cfg_t   cfg_reg;
  logic [71:0]         wlvl_reg;
  logic [1:0]          downscale_reg;
  logic [23:0]         ch_en_reg;
  logic [23:0]         int_en_reg;
  sss_pkg::sss_clean_t clean_reg;
  logic [23:0]         clean_mask_reg;
  logic [1:0]          comp_level_reg;

  // sequencer state
  sss_pkg::sss_state_t state_reg;
  sss_pkg::sss_state_t state_next;
  logic [4:0]          ch_reg;
  logic [4:0]          ch_next;
  logic [16:0]         win_cnt_reg;
  logic [16:0]         win_cnt_next;
  logic [27:0]         per_cnt_reg;
  logic [23:0]         ref_reg;
  logic                first_reg;
  logic                chg_acc_reg;
  logic [23:0]         reduced_reg;
  logic [23:0][1:0]    stab_cnt_reg;
  logic                flag_reg;
  logic                ack_pend_reg;
  logic                cs_n_q_reg;
  logic [23:0][2:0]    current_next;

  function automatic logic [16:0] win_cycles(input logic [2:0] sel);
    win_cycles = 17'(ACT_BASE_CYC) << sel;
  endfunction : win_cycles

  function automatic logic [2:0] ch_level(input logic [71:0] all,
                                          input int unsigned i);
    ch_level = all[3*i +: 3];
  endfunction : ch_level

  // register decode
  wire wr_cfg    = wr && (addr == sss_pkg::OFS_CONFIG);
  wire wr_wla    = wr && (addr == sss_pkg::OFS_WLVL_A);
  wire wr_wlb    = wr && (addr == sss_pkg::OFS_WLVL_B);
  wire wr_wlc    = wr && (addr == sss_pkg::OFS_WLVL_C);
  wire wr_down   = wr && (addr == sss_pkg::OFS_DOWNSCALE);
  wire wr_en     = wr && (addr == sss_pkg::OFS_CH_ENABLE);
  wire wr_ien    = wr && (addr == sss_pkg::OFS_INT_ENABLE);
  wire wr_clean  = wr && (addr == sss_pkg::OFS_CLEAN_LEVEL);
  wire wr_cmask  = wr && (addr == sss_pkg::OFS_CLEAN_MASK);
  wire wr_comp   = wr && (addr == sss_pkg::OFS_COMP_LEVEL);
  wire rd_int    = rd && (addr == sss_pkg::OFS_INT_STATUS);

  wire [31:0] rd_mux =
    (addr == sss_pkg::OFS_CONFIG)      ? {20'h00000, cfg_reg} :
    (addr == sss_pkg::OFS_WLVL_A)      ? {8'h00, wlvl_reg[23:0]} :
    (addr == sss_pkg::OFS_WLVL_B)      ? {8'h00, wlvl_reg[47:24]} :
    (addr == sss_pkg::OFS_WLVL_C)      ? {8'h00, wlvl_reg[71:48]} :
    (addr == sss_pkg::OFS_DOWNSCALE)   ? {30'h00000000, downscale_reg} :
    (addr == sss_pkg::OFS_CH_ENABLE)   ? {8'h00, ch_en_reg} :
    (addr == sss_pkg::OFS_INT_ENABLE)  ? {8'h00, int_en_reg} :
    (addr == sss_pkg::OFS_CLEAN_LEVEL) ? {26'h0000000, clean_reg} :
    (addr == sss_pkg::OFS_CLEAN_MASK)  ? {8'h00, clean_mask_reg} :
    (addr == sss_pkg::OFS_COMP_LEVEL)  ? {30'h00000000, comp_level_reg} :
    (addr == sss_pkg::OFS_COMP_STATUS) ? {8'h00, ref_reg} :
    (addr == sss_pkg::OFS_INT_STATUS)  ? {31'h00000000, flag_reg} :
    (addr == sss_pkg::OFS_SCALE_STAT)  ? {8'h00, reduced_reg} :
                                         32'h00000000;

  // go rising starts a fresh sequence; go low stops everything
  wire start = wr_cfg && wdata[0] && !cfg_reg.go;
  wire run   = cfg_reg.go;

  // sequencing terms
  wire [16:0] win_len     = win_cycles(cfg_reg.active_window_sel);
  wire [16:0] clean_len   = win_cycles(clean_reg.window_sel);
  wire [27:0] period_len  = 28'(POLL_BASE_CYC) << cfg_reg.period_sel;
  // disabled inputs cost one cycle each; only enabled ones get a window
  wire        ch_on       = ch_en_reg[ch_reg];
  wire        win_end     = (win_cnt_reg == win_len - 17'h00001);
  wire        sample_now  = (state_reg == sss_pkg::SSS_SCAN) && ch_on &&
                            win_end;
  wire        step_done   = (state_reg == sss_pkg::SSS_SCAN) &&
                            (!ch_on || win_end);
  wire        scan_done   = step_done && (ch_reg == sss_pkg::LAST_CH);
  wire        differs     = sample_now && (comp_above != ref_reg[ch_reg]);
  // the channel's interrupt enable gates its change in both modes
  wire        chg_seen    = chg_acc_reg ||
                            (differs && int_en_reg[ch_reg]);
  wire        clean_any   = cfg_reg.clean_en &&
                            |(ch_en_reg & clean_mask_reg);
  wire        period_end  = (per_cnt_reg >= period_len - 28'h0000001);
  wire        cycle_event = scan_done && (first_reg || chg_seen);
  // clearing waits for the select rise, so a read in flight keeps int_n
  wire        cs_rise     = cs_n && !cs_n_q_reg;
  wire        int_clear   = ack_pend_reg && cs_rise;
  wire        flag_next   = cycle_event || (flag_reg && !int_clear);

  // state machine
  always_comb begin
    state_next   = state_reg;
    ch_next      = ch_reg;
    win_cnt_next = win_cnt_reg + 17'h00001;
    case (state_reg)
      sss_pkg::SSS_IDLE: begin
        win_cnt_next = 17'h00000;
      end
      sss_pkg::SSS_STARTUP: begin
        if (win_cnt_reg == 17'(STARTUP_CYC - 1)) begin
          state_next   = sss_pkg::SSS_SCAN;
          ch_next      = 5'h00;
          win_cnt_next = 17'h00000;
        end
      end
      sss_pkg::SSS_SCAN: begin
        if (step_done) begin
          win_cnt_next = 17'h00000;
          ch_next      = ch_reg + 5'h01;
          if (scan_done) begin
            ch_next    = 5'h00;
            state_next = clean_any ? sss_pkg::SSS_GAP : sss_pkg::SSS_WAIT;
          end
        end
      end
      sss_pkg::SSS_GAP: begin
        if (win_cnt_reg == 17'(sss_pkg::CLEAN_GAP_CYC - 1)) begin
          state_next   = sss_pkg::SSS_CLEAN;
          win_cnt_next = 17'h00000;
        end
      end
      sss_pkg::SSS_CLEAN: begin
        if (win_cnt_reg == clean_len - 17'h00001) begin
          state_next   = sss_pkg::SSS_WAIT;
          win_cnt_next = 17'h00000;
        end
      end
      sss_pkg::SSS_WAIT: begin
        win_cnt_next = 17'h00000;
        if (period_end) begin
          state_next = sss_pkg::SSS_SCAN;
        end
      end
      default: begin
        state_next   = sss_pkg::SSS_IDLE;
        win_cnt_next = 17'h00000;
      end
    endcase
    // a go rise overrides every state, so a restart is always fresh
    if (start) begin
      state_next   = sss_pkg::SSS_STARTUP;
      ch_next      = 5'h00;
      win_cnt_next = 17'h00000;
    end else if (!run) begin
      state_next   = sss_pkg::SSS_IDLE;
      ch_next      = 5'h00;
      win_cnt_next = 17'h00000;
    end
  end

  // current drive per input; the cleaning step overrides the scan level,
  // in both modes; in continuous it replaces a level already driven
  always_comb begin
    logic       live;
    logic [2:0] lvl;
    live = (state_reg != sss_pkg::SSS_IDLE) &&
           (state_reg != sss_pkg::SSS_STARTUP);
    lvl  = sss_pkg::LVL_0MA;
    for (int unsigned i = 0; i < sss_pkg::NUM_CH; i++) begin
      lvl = reduced_reg[i] ? sss_pkg::LVL_2MA : ch_level(wlvl_reg, i);
      current_next[i] = sss_pkg::LVL_0MA;
      if (live && ch_en_reg[i]) begin
        if (!cfg_reg.poll_mode) begin
          current_next[i] = lvl;
        end else if ((state_reg == sss_pkg::SSS_SCAN) &&
                     (ch_reg == 5'(i))) begin
          current_next[i] = lvl;
        end
        if ((state_reg == sss_pkg::SSS_CLEAN) && clean_mask_reg[i]) begin
          current_next[i] = clean_reg.level;
        end
      end
    end
  end

  // register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg        <= sss_pkg::RST_CONFIG;
      wlvl_reg       <= {3{sss_pkg::RST_WLVL}};
      downscale_reg  <= 2'h0;
      ch_en_reg      <= sss_pkg::RST_CH_ENABLE;
      int_en_reg     <= sss_pkg::RST_INT_ENABLE;
      clean_reg      <= sss_pkg::RST_CLEAN_LVL;
      clean_mask_reg <= sss_pkg::RST_CLEAN_MASK;
      comp_level_reg <= 2'h0;
    end else begin
      if (wr_cfg)   cfg_reg          <= wdata[11:0];
      if (wr_wla)   wlvl_reg[23:0]   <= wdata[23:0];
      if (wr_wlb)   wlvl_reg[47:24]  <= wdata[23:0];
      if (wr_wlc)   wlvl_reg[71:48]  <= wdata[23:0];
      if (wr_down)  downscale_reg    <= wdata[1:0];
      if (wr_en)    ch_en_reg        <= wdata[23:0];
      if (wr_ien)   int_en_reg       <= wdata[23:0];
      if (wr_clean) clean_reg        <= wdata[5:0];
      if (wr_cmask) clean_mask_reg   <= wdata[23:0];
      if (wr_comp)  comp_level_reg   <= wdata[1:0];
    end
  end

  // sequencer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= sss_pkg::SSS_IDLE;
      ch_reg      <= 5'h00;
      win_cnt_reg <= 17'h00000;
      per_cnt_reg <= 28'h0000000;
    end else begin
      state_reg   <= state_next;
      ch_reg      <= ch_next;
      win_cnt_reg <= win_cnt_next;
      // period runs from the first step of each cycle
      if (state_next == sss_pkg::SSS_SCAN &&
          state_reg != sss_pkg::SSS_SCAN) begin
        per_cnt_reg <= 28'h0000000;
      end else if (!period_end) begin
        per_cnt_reg <= per_cnt_reg + 28'h0000001;
      end
    end
  end

  // reference states and cycle bookkeeping; cleaning never touches these
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_reg     <= 24'h000000;
      first_reg   <= 1'b0;
      chg_acc_reg <= 1'b0;
    end else begin
      if (sample_now) begin
        ref_reg[ch_reg] <= comp_above;
      end
      if (start) begin
        first_reg   <= 1'b1;
        chg_acc_reg <= 1'b0;
      end else if (scan_done) begin
        first_reg   <= 1'b0;
        chg_acc_reg <= 1'b0;
      end else begin
        chg_acc_reg <= chg_seen;
      end
    end
  end

  // downscaling with stability filter; the filter counts prior samples
  // that agreed, so code n flips on the (n+1)th consecutive sample
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reduced_reg  <= 24'h000000;
      stab_cnt_reg <= '0;
    end else begin
      for (int unsigned i = 0; i < sss_pkg::NUM_CH; i++) begin
        logic [2:0] lv;
        logic       off;
        logic       elig;
        logic       toward;
        lv     = ch_level(wlvl_reg, i);
        off    = (5'(i) < sss_pkg::SINK_CH_COUNT) ? downscale_reg[1] :
                                                   downscale_reg[0];
        elig   = run && !cfg_reg.poll_mode && !off &&
                 (lv == sss_pkg::LVL_10MA || lv == sss_pkg::LVL_15MA);
        toward = reduced_reg[i] ? !comp_above : comp_above;
        if (!elig) begin
          reduced_reg[i]  <= 1'b0;
          stab_cnt_reg[i] <= 2'h0;
        end else if (sample_now && ch_reg == 5'(i)) begin
          if (!toward) begin
            stab_cnt_reg[i] <= 2'h0;
          end else if (stab_cnt_reg[i] >= cfg_reg.stability_count_sel) begin
            reduced_reg[i]  <= !reduced_reg[i];
            stab_cnt_reg[i] <= 2'h0;
          end else begin
            stab_cnt_reg[i] <= stab_cnt_reg[i] + 2'h1;
          end
        end
      end
    end
  end

  // change flag: a new event in the clearing cycle wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg     <= 1'b0;
      ack_pend_reg <= 1'b0;
      cs_n_q_reg   <= 1'b1;
    end else begin
      flag_reg   <= flag_next;
      cs_n_q_reg <= cs_n;
      if (cs_rise) begin
        ack_pend_reg <= 1'b0;
      end else if (rd_int && !cs_n) begin
        ack_pend_reg <= 1'b1;
      end
    end
  end

  // outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata              <= 32'h00000000;
      comp_sel           <= 5'h00;
      current_sel        <= '0;
      threshold_sel      <= 2'h0;
      int_n              <= 1'b1;
      switch_change_flag <= 1'b0;
    end else begin
      rdata              <= rd ? rd_mux : 32'h00000000;
      comp_sel           <= ch_next;
      current_sel        <= current_next;
      threshold_sel      <= comp_level_reg;
      int_n              <= !flag_next;
      switch_change_flag <= flag_next;
    end
  end

endmodule : sss_top

// ### rtl/sss_pkg.sv
// package for the switch scan sequencer: register map, field layout,
// reset values, timing constants, state and configuration types.
// assumes a 25 MHz core clock and one 32-bit word per register.
package sss_pkg;

  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned NUM_CH  = 24;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG      = 8'h00;
  localparam logic [7:0] OFS_WLVL_A      = 8'h04;
  localparam logic [7:0] OFS_WLVL_B      = 8'h08;
  localparam logic [7:0] OFS_WLVL_C      = 8'h0C;
  localparam logic [7:0] OFS_DOWNSCALE   = 8'h10;
  localparam logic [7:0] OFS_CH_ENABLE   = 8'h14;
  localparam logic [7:0] OFS_INT_ENABLE  = 8'h18;
  localparam logic [7:0] OFS_CLEAN_LEVEL = 8'h1C;
  localparam logic [7:0] OFS_CLEAN_MASK  = 8'h20;
  localparam logic [7:0] OFS_COMP_LEVEL  = 8'h24;
  localparam logic [7:0] OFS_COMP_STATUS = 8'h28;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h2C;
  localparam logic [7:0] OFS_SCALE_STAT  = 8'h30;

  // reset values
  localparam logic [11:0] RST_CONFIG     = 12'h000;
  localparam logic [23:0] RST_WLVL       = 24'h000000;
  localparam logic [23:0] RST_CH_ENABLE  = 24'h000000;
  localparam logic [23:0] RST_INT_ENABLE = 24'hFFFFFF;
  localparam logic [5:0]  RST_CLEAN_LVL  = 6'h00;
  localparam logic [23:0] RST_CLEAN_MASK = 24'hFFFFFF;

  // wetting level codes: 0, 1, 2, 5, 10, 15 mA
  localparam logic [2:0] LVL_0MA  = 3'h0;
  localparam logic [2:0] LVL_2MA  = 3'h2;
  localparam logic [2:0] LVL_10MA = 3'h4;
  localparam logic [2:0] LVL_15MA = 3'h5;

  // inputs below this index are the sink-capable ones
  localparam logic [4:0] SINK_CH_COUNT = 5'h0A;
  localparam logic [4:0] LAST_CH       = 5'h17;

  // timing, in their own units, and derived cycle counts
  localparam int unsigned POLL_BASE_MS   = 2;
  localparam int unsigned ACT_BASE_US    = 64;
  localparam int unsigned STARTUP_US     = 200;
  localparam int unsigned CLEAN_GAP_US   = 50;
  localparam int unsigned POLL_BASE_CYC  = POLL_BASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned ACT_BASE_CYC   = ACT_BASE_US * CLK_MHZ;
  localparam int unsigned STARTUP_CYC    = STARTUP_US * CLK_MHZ;
  localparam int unsigned CLEAN_GAP_CYC  = CLEAN_GAP_US * CLK_MHZ;

  typedef enum logic [2:0] {
    SSS_IDLE    = 3'h0,
    SSS_STARTUP = 3'h1,
    SSS_SCAN    = 3'h3,
    SSS_GAP     = 3'h2,
    SSS_CLEAN   = 3'h6,
    SSS_WAIT    = 3'h7
  } sss_state_t;

  // configuration word, go bit at bit 0
  typedef struct packed {
    logic       clean_en;
    logic [2:0] active_window_sel;
    logic [3:0] period_sel;
    logic [1:0] stability_count_sel;
    logic       poll_mode;
    logic       go;
  } sss_cfg_t;

  typedef struct packed {
    logic [2:0] window_sel;
    logic [2:0] level;
  } sss_clean_t;

endpackage : sss_pkg

// ### test/sss_top_asserts.sv
// concurrent checks on the ports of the switch scan sequencer.
// assumes one clock domain and the register map of sss_pkg.
module sss_top_asserts (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic [7:0]        addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [31:0]       rdata,
  input wire logic              cs_n,
  input wire logic              comp_above,
  input wire logic [4:0]        comp_sel,
  input wire logic [23:0][2:0]  current_sel,
  input wire logic [1:0]        threshold_sel,
  input wire logic              int_n,
  input wire logic              switch_change_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        go_reg;
  logic        poll_reg;
  logic        clean_reg;
  logic [23:0] on_vec;
  wire         cfg_wr = wr && (addr == sss_pkg::OFS_CONFIG);

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // shadow of the mode bits, so polling checks know when they apply
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      go_reg    <= 1'b0;
      poll_reg  <= 1'b0;
      clean_reg <= 1'b0;
    end else if (cfg_wr) begin
      go_reg    <= wdata[0];
      poll_reg  <= wdata[1];
      clean_reg <= wdata[11];
    end
  end

  always_comb begin
    for (int i = 0; i < 24; i++) begin
      on_vec[i] = (current_sel[i] != 3'h0);
    end
  end

  AST_INT_MIRROR: assert property (int_n == !switch_change_flag)
    else $error("interrupt line disagrees with change flag");
  AST_CLEAR_ON_CS: assert property ($fell(switch_change_flag) |->
    $past(cs_n) && !$past(cs_n, 2))
    else $error("change flag cleared without chip select rise");
  AST_FLAG_HOLDS: assert property (switch_change_flag && !wr &&
    !(cs_n && !$past(cs_n)) |=> switch_change_flag)
    else $error("change flag dropped on its own");
  AST_POLL_ONE_ON: assert property (poll_reg && go_reg && !clean_reg
    |-> $onehot0(on_vec))
    else $error("more than one input powered in polling");
  AST_STARTUP_IDLE: assert property (cfg_wr && wdata[0] && !go_reg
    |=> (current_sel == '0) [*3])
    else $error("current applied before startup delay");
  AST_GO_OFF: assert property (cfg_wr && !wdata[0]
    |-> ##[1:4] (current_sel == '0))
    else $error("currents still on after stop");
  AST_THRESH_COPY: assert property (wr && addr ==
    sss_pkg::OFS_COMP_LEVEL ##2 1'b1 |-> threshold_sel == $past(wdata[1:0], 2))
    else $error("threshold select not following its register");
  AST_ASCEND: assert property ($changed(comp_sel) |->
    comp_sel == $past(comp_sel) + 5'h01 || comp_sel == 5'h00)
    else $error("comparator routing out of ascending order");
endmodule : sss_top_asserts

bind sss_top sss_top_asserts u_chk (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .cs_n(cs_n), .comp_above(comp_above), .comp_sel(comp_sel),
  .current_sel(current_sel), .threshold_sel(threshold_sel),
  .int_n(int_n), .switch_change_flag(switch_change_flag));

// ### test/sss_switch_model.sv
// behavioural bank of switches seen through the routed comparator.
// assumes the bench sets which switches are closed.
module sss_switch_model (
  input  wire logic [4:0]  comp_sel,
  input  wire logic [23:0] closed,
  output logic             comp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  // an index past the last input reads open, like an unbonded pin
  assign comp_above = (comp_sel <= sss_pkg::LAST_CH) ? closed[comp_sel]
                                                     : 1'b0;
endmodule : sss_switch_model

// ### test/tb_top.sv
// self-checking bench for the switch scan sequencer.
// assumes the checker is bound and counts are shortened by parameters.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk;
  logic             reset_n;
  logic [7:0]       addr;
  logic [31:0]      wdata;
  logic             wr;
  logic             rd;
  logic [31:0]      rdata;
  logic             cs_n;
  logic             comp_above;
  logic [4:0]       comp_sel;
  logic [23:0][2:0] current_sel;
  logic [1:0]       threshold_sel;
  logic             int_n;
  logic             switch_change_flag;
  logic [23:0]      closed;
  int               mismatches;
  int               checked;

  sss_top #(.POLL_BASE_CYC(200), .ACT_BASE_CYC(4), .STARTUP_CYC(3)) uut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cs_n(cs_n), .comp_above(comp_above),
    .comp_sel(comp_sel), .current_sel(current_sel),
    .threshold_sel(threshold_sel), .int_n(int_n),
    .switch_change_flag(switch_change_flag));
  sss_switch_model u_sw (.comp_sel(comp_sel), .closed(closed),
    .comp_above(comp_above));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask : rd_reg

  task automatic wait_flag(input int n);
    for (int i = 0; i < n && switch_change_flag !== 1'b1; i++) @(posedge clk);
    #1;
    chk(32'(switch_change_flag), 32'h1, "change flag");
    chk(32'(int_n), 32'h0, "interrupt line");
  endtask : wait_flag

  task automatic quiet(input int n);
    cycles(n);
    #1;
    chk(32'(switch_change_flag), 32'h0, "flag stays clear");
  endtask : quiet

  task automatic ack();
    @(posedge clk);
    cs_n <= 1'b0;
    rd_reg(sss_pkg::OFS_INT_STATUS, 32'h1, "int status");
    @(posedge clk);
    cs_n <= 1'b1;
    cycles(3);
    #1;
    chk(32'(switch_change_flag), 32'h0, "flag cleared");
    chk(32'(int_n), 32'h1, "line released");
  endtask : ack

  // stop first so the go bit rises from zero and the first cycle is fresh
  task automatic start(input logic [31:0] cfg);
    wr_reg(sss_pkg::OFS_CONFIG, 32'h0);
    cycles(6);
    wr_reg(sss_pkg::OFS_CONFIG, cfg);
  endtask : start

  // input 3 is set to no current, so follow the routing instead; returns
  // just after its step, far from the next window of input 0
  task automatic wait_ch3();
    for (int i = 0; i < 4000 && comp_sel !== 5'h03; i++) @(posedge clk);
    for (int i = 0; i < 100 && comp_sel === 5'h03; i++) @(posedge clk);
  endtask : wait_ch3

  task automatic t_reset();
    rd_reg(sss_pkg::OFS_INT_ENABLE, 32'(sss_pkg::RST_INT_ENABLE), "ien");
    rd_reg(sss_pkg::OFS_CLEAN_MASK, 32'(sss_pkg::RST_CLEAN_MASK), "cmask");
    rd_reg(sss_pkg::OFS_CH_ENABLE, 32'(sss_pkg::RST_CH_ENABLE), "chen");
    rd_reg(8'h3C, 32'h0, "unmapped");
    chk(32'(int_n), 32'h1, "idle line");
    $display("test reset done");
  endtask : t_reset

  task automatic t_cont();
    wr_reg(sss_pkg::OFS_WLVL_A, 32'h000000E9);
    wr_reg(sss_pkg::OFS_CH_ENABLE, 32'h0000000F);
    wr_reg(sss_pkg::OFS_DOWNSCALE, 32'h0);
    wr_reg(sss_pkg::OFS_COMP_LEVEL, 32'h2);
    closed <= 24'h00000A;
    start(32'h00000035);
    wait_flag(3000);
    rd_reg(sss_pkg::OFS_COMP_STATUS, 32'hA, "ref state");
    chk(32'(current_sel[0]), 32'h1, "ch0 level");
    chk(32'(current_sel[2]), 32'h3, "ch2 level");
    chk(32'(current_sel[3]), 32'h0, "ch3 level");
    chk(32'(threshold_sel), 32'h2, "threshold");
    chk(32'(current_sel[1]), 32'(sss_pkg::LVL_15MA), "filtered");
    cycles(1700);
    #1;
    chk(32'(current_sel[1]), 32'(sss_pkg::LVL_2MA), "scaled");
    rd_reg(sss_pkg::OFS_SCALE_STAT, 32'h2, "scale stat");
    @(posedge clk);
    cs_n <= 1'b0;
    cycles(2);
    cs_n <= 1'b1;
    cycles(3);
    chk(32'(switch_change_flag), 32'h1, "flag kept");
    ack();
    closed <= 24'h000008;
    wait_flag(3400);
    chk(32'(current_sel[1]), 32'(sss_pkg::LVL_2MA), "held");
    cycles(1700);
    #1;
    chk(32'(current_sel[1]), 32'(sss_pkg::LVL_15MA), "restored");
    ack();
    quiet(3400);
    $display("test continuous done");
  endtask : t_cont

  task automatic t_poll();
    wr_reg(sss_pkg::OFS_INT_ENABLE, 32'h00FFFFF9);
    start(32'h00000033);
    wait_flag(3400);
    ack();
    closed <= 24'h00000E;
    quiet(3400);
    rd_reg(sss_pkg::OFS_COMP_STATUS, 32'hE, "ref poll");
    rd_reg(sss_pkg::OFS_SCALE_STAT, 32'h0, "no scaling");
    wait_ch3();
    closed <= 24'h00000F;
    cycles(5);
    closed <= 24'h00000E;
    quiet(3400);
    rd_reg(sss_pkg::OFS_COMP_STATUS, 32'hE, "glitch unseen");
    $display("test polling done");
  endtask : t_poll

  task automatic t_clean();
    int n;
    wr_reg(sss_pkg::OFS_CLEAN_LEVEL, 32'h4);
    wr_reg(sss_pkg::OFS_CLEAN_MASK, 32'h1);
    start(32'h00000833);
    wait_flag(3400);
    ack();
    wait_ch3();
    for (n = 0; n < 3400 && current_sel[0] !== 3'h4; n++) @(posedge clk);
    chk(32'(n >= 1250 && n <= 1300), 32'h1, "gap");
    chk(32'(current_sel[0]), 32'h4, "clean level");
    chk(32'(current_sel[1]), 32'h0, "masked input");
    quiet(3400);
    $display("test cleaning done");
  endtask : t_clean

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(40 * 60000);
    mismatches++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    cs_n = 1'b1;
    closed = 24'h0;
    mismatches = 0;
    checked = 0;
    cycles(3);
    reset_n <= 1'b1;
    t_reset();
    t_cont();
    t_poll();
    t_clean();
    stop_test();
  end
endmodule : tb_top
